/* common/ssdl_regs.svh */
// field positions, field encodings, reset values and region constants
`ifndef SSDL_REGS_SVH
`define SSDL_REGS_SVH
// ==========================================================
// register fields of smm_space_control
`define SSDL_GMS_HI 7
`define SSDL_GMS_LO 6
`define SSDL_UPPER_SMM_SELECT_HI 5
`define SSDL_UPPER_SMM_SELECT_LO 4
`define SSDL_LOW_SMM_SELECT_HI 3
`define SSDL_LOW_SMM_SELECT_LO 2
`define SSDL_LOCK_BIT 1
`define SSDL_VIOL_BIT 0
`define SSDL_CTRL_RESET 8'h00
// ==========================================================
// field encodings
`define SSDL_SEL_00 2'h0
`define SSDL_SEL_01 2'h1
`define SSDL_SEL_10 2'h2
`define SSDL_SEL_11 2'h3
// ==========================================================
// address ranges
`define SSDL_AB_BASE 32'h000A_0000
`define SSDL_AB_LAST 32'h000B_FFFF
`define SSDL_HIGH_REMAP_SMM_SEGMENT_BASE 32'hFEEA_0000
`define SSDL_HIGH_REMAP_SMM_SEGMENT_LAST 32'hFEEB_FFFF
`define SSDL_TOP_SMM_SEGMENT_512K 32'h0008_0000
`define SSDL_TOP_SMM_SEGMENT_1M 32'h0010_0000
`define SSDL_ROWPOP_RESET 8'h00
`endif

/* common/ssdl_pkg.sv */
// types shared by the smm decode block
package ssdl_pkg;
  // where an access is sent
  typedef enum logic [1:0] {
    SSDL_DST_DRAM,
    SSDL_DST_HUB,
    SSDL_DST_GFX,
    SSDL_DST_BLOCK
  } ssdl_dest_t;
  // decode pipeline state
  typedef enum logic {
    SSDL_IDLE,
    SSDL_ANSWER
  } ssdl_state_t;
endpackage

/* common/ssdl_cfg_if.sv */
// carrier for the configuration write path to the row register file
`timescale 1ns/1ns
`default_nettype none
interface ssdl_cfg_if;
  logic wr_en; // write strobe
  logic sel; // row register index
  logic [7:0] wdata; // write data
  logic lock; // lock state
  logic [7:0] rdata0; // first row register
  logic [7:0] rdata1; // second row register
  modport ctrl (output wr_en, sel, wdata, lock, input rdata0, rdata1);
  modport mem (input wr_en, sel, wdata, lock, output rdata0, rdata1);
endinterface
`default_nettype wire

/* rtl/ssdl_rowpop.sv */
// lockable pair of dram row population registers
`timescale 1ns/1ns
`default_nettype none
`include "ssdl_regs.svh"
module ssdl_rowpop (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  ssdl_cfg_if.mem cfg
);
  import ssdl_pkg::*;
  // ==========================================================
  // storage
  logic [7:0] row [2]; // row population registers
  logic [7:0] next_row [2]; // next values
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_row
      // writes are dropped while locked
      always_comb begin
        next_row[gi] = row[gi];
        if (cfg.wr_en && !cfg.lock && (cfg.sel == 1'(gi))) begin
          next_row[gi] = cfg.wdata;
        end
      end
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          row[gi] <= `SSDL_ROWPOP_RESET;
        end else if (clk_en_in) begin
          row[gi] <= next_row[gi];
        end
      end
    end
  endgenerate
  // read data straight from the registers
  assign cfg.rdata0 = row[0];
  assign cfg.rdata1 = row[1];
  // locked row register keeps its value across a write
  property p_row_lock;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && cfg.lock && cfg.wr_en) |=>
      $stable(row[0]) && $stable(row[1]);
  endproperty
  a_row_lock: assert property (p_row_lock)
    else $error("row reg changed");
endmodule
`default_nettype wire

/* rtl/ssdl_top.sv */
// smm space control register and smm region decode
`timescale 1ns/1ns
`default_nettype none
`include "ssdl_regs.svh"
module ssdl_top (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic cfg_wr_in, // config write strobe
  input wire logic [1:0] cfg_sel_in, // 0 ctrl, 2 row0, 3 row1
  input wire logic [7:0] cfg_wdata_in,
  input wire logic [31:0] tom_in, // top of memory byte address
  input wire logic req_valid_in, // one access per pulse
  input wire logic [31:0] req_addr_in,
  input wire logic req_cpu_in, // access from the processor
  input wire logic req_smm_in, // processor in SMM
  input wire logic req_code_in, // code fetch
  input wire logic req_write_in,
  input wire logic req_wb_in, // explicit write-back
  output logic [7:0] ctrl_out, // smm_space_control readback
  output logic [7:0] rowpop0_out,
  output logic [7:0] rowpop1_out,
  output logic rsp_valid_out,
  output var ssdl_pkg::ssdl_dest_t rsp_dest_out
);
  import ssdl_pkg::*;
  // ==========================================================
  // control register fields
  logic [1:0] graphics_memory_select, next_gms; // graphics_memory_select
  logic [1:0] upper_smm_select, next_upper;
  logic [1:0] low_smm_select, next_low;
  logic smm_space_lock, next_lock;
  logic viol_flag, next_viol; // extended_smm_violation_flag
  logic hit_viol; // violation event this cycle
  ssdl_cfg_if cfg ();
  // ==========================================================
  // register write logic
  always_comb begin
    next_gms = graphics_memory_select;
    next_upper = upper_smm_select;
    next_low = low_smm_select;
    next_lock = smm_space_lock;
    next_viol = viol_flag;
    if (cfg_wr_in && cfg_sel_in == 2'h0) begin
      if (!smm_space_lock) begin
        next_gms = cfg_wdata_in[`SSDL_GMS_HI:`SSDL_GMS_LO];
        next_upper = cfg_wdata_in[`SSDL_UPPER_SMM_SELECT_HI:`SSDL_UPPER_SMM_SELECT_LO];
        next_low[1] = cfg_wdata_in[`SSDL_LOW_SMM_SELECT_HI];
        next_low[0] = cfg_wdata_in[`SSDL_LOW_SMM_SELECT_LO];
      end else if (low_smm_select[1]) begin
        next_low[0] = cfg_wdata_in[`SSDL_LOW_SMM_SELECT_LO];
      end
      // zero writes never clear the lock
      if (cfg_wdata_in[`SSDL_LOCK_BIT]) begin
        next_lock = 1'b1;
      end
      if (cfg_wdata_in[`SSDL_VIOL_BIT]) begin
        next_viol = 1'b0;
      end
    end
    // set wins over a same-cycle clear
    if (hit_viol) begin
      next_viol = 1'b1;
    end
  end
  // reset clears every field
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      graphics_memory_select <= 2'h0;
      upper_smm_select <= 2'h0;
      low_smm_select <= 2'h0;
      smm_space_lock <= 1'b0;
      viol_flag <= 1'b0;
    end else if (clk_en_in) begin
      graphics_memory_select <= next_gms;
      upper_smm_select <= next_upper;
      low_smm_select <= next_low;
      smm_space_lock <= next_lock;
      viol_flag <= next_viol;
    end
  end
  // ==========================================================
  // row population registers
  assign cfg.wr_en = cfg_wr_in && cfg_sel_in[1];
  assign cfg.sel = cfg_sel_in[0];
  assign cfg.wdata = cfg_wdata_in;
  assign cfg.lock = smm_space_lock;
  ssdl_rowpop u_rowpop (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .cfg(cfg.mem)
  );
  // ==========================================================
  // region decode
  logic top_smm_segment_en, high_remap_smm_segment_en; // segment enables
  logic [31:0] top_smm_segment_size, top_smm_segment_base;
  logic in_ab, in_high_remap_smm_segment, in_top_smm_segment;
  logic ab_dram; // AB access may reach dram
  ssdl_dest_t dest;
  always_comb begin
    top_smm_segment_en = 1'b0;
    high_remap_smm_segment_en = 1'b0;
    top_smm_segment_size = `SSDL_TOP_SMM_SEGMENT_1M;
    case (upper_smm_select)
      `SSDL_SEL_00: begin
        top_smm_segment_en = 1'b0;
      end
      `SSDL_SEL_01: begin
        high_remap_smm_segment_en = 1'b1;
      end
      `SSDL_SEL_10: begin
        top_smm_segment_en = 1'b1;
        high_remap_smm_segment_en = 1'b1;
        top_smm_segment_size = `SSDL_TOP_SMM_SEGMENT_512K;
      end
      `SSDL_SEL_11: begin
        top_smm_segment_en = 1'b1;
        high_remap_smm_segment_en = 1'b1;
      end
      default: begin
        top_smm_segment_en = 1'b0;
      end
    endcase
    // high segment only with the AB window closed
    if (low_smm_select != `SSDL_SEL_00) begin
      high_remap_smm_segment_en = 1'b0;
    end
  end
  // top segment sits just below top of memory
  assign top_smm_segment_base = tom_in - top_smm_segment_size;
  assign in_ab = (req_addr_in >= `SSDL_AB_BASE) &&
                 (req_addr_in <= `SSDL_AB_LAST);
  assign in_high_remap_smm_segment = high_remap_smm_segment_en && (req_addr_in >= `SSDL_HIGH_REMAP_SMM_SEGMENT_BASE) &&
                   (req_addr_in <= `SSDL_HIGH_REMAP_SMM_SEGMENT_LAST);
  assign in_top_smm_segment = top_smm_segment_en && (req_addr_in >= top_smm_segment_base) &&
                   (req_addr_in < tom_in);
  // non-SMM processor hits, write-backs excepted
  assign hit_viol = req_valid_in && req_cpu_in && !req_smm_in &&
                    !req_wb_in && (in_high_remap_smm_segment || in_top_smm_segment);
  always_comb begin
    ab_dram = 1'b0;
    case (low_smm_select)
      `SSDL_SEL_00: ab_dram = 1'b0;
      `SSDL_SEL_01: ab_dram = 1'b1;
      `SSDL_SEL_10: ab_dram = req_cpu_in && req_smm_in && req_code_in &&
                              !req_write_in;
      `SSDL_SEL_11: ab_dram = req_cpu_in && req_smm_in;
      default: ab_dram = 1'b0;
    endcase
    dest = SSDL_DST_DRAM;
    if (in_high_remap_smm_segment || in_top_smm_segment) begin
      // only SMM processor cycles hit dram here
      dest = (req_cpu_in && req_smm_in) ? SSDL_DST_DRAM
                                        : SSDL_DST_HUB;
    end else if (in_ab) begin
      if (ab_dram) begin
        dest = SSDL_DST_DRAM;
      end else if (graphics_memory_select != `SSDL_SEL_00) begin
        dest = SSDL_DST_GFX; // graphics claims VGA range
      end else begin
        dest = SSDL_DST_HUB;
      end
    end
  end
  // ==========================================================
  // registered outputs
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rsp_valid_out <= 1'b0;
      rsp_dest_out <= SSDL_DST_DRAM;
      ctrl_out <= `SSDL_CTRL_RESET;
      rowpop0_out <= `SSDL_ROWPOP_RESET;
      rowpop1_out <= `SSDL_ROWPOP_RESET;
    end else if (clk_en_in) begin
      rsp_valid_out <= req_valid_in;
      rsp_dest_out <= dest;
      ctrl_out <= {next_gms, next_upper, next_low, next_lock, next_viol};
      rowpop0_out <= cfg.rdata0;
      rowpop1_out <= cfg.rdata1;
    end
  end
  // ==========================================================
  // checks
  // processor touches an enabled upper range outside SMM
  sequence s_nonsmm_hit;
    clk_en_in && req_valid_in && req_cpu_in && !req_smm_in && !req_wb_in &&
    (in_high_remap_smm_segment || in_top_smm_segment);
  endsequence
  // the same access as an explicit write-back, flag still clear
  sequence s_wb_hit;
    clk_en_in && !viol_flag && req_valid_in && req_cpu_in && !req_smm_in &&
    req_wb_in && (in_high_remap_smm_segment || in_top_smm_segment);
  endsequence
  property p_viol_set;
    @(posedge mclk_in) disable iff (reset_in)
      s_nonsmm_hit |=> viol_flag;
  endproperty
  a_viol_set: assert property (p_viol_set)
    else $error("flag not set");
  property p_wb_quiet;
    @(posedge mclk_in) disable iff (reset_in)
      s_wb_hit |=> !viol_flag;
  endproperty
  a_wb_quiet: assert property (p_wb_quiet)
    else $error("wb set flag");
  property p_lock_sticky;
    @(posedge mclk_in) disable iff (reset_in)
      smm_space_lock |=> smm_space_lock && $stable(upper_smm_select) &&
      $stable(graphics_memory_select) && $stable(low_smm_select[1]);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock broke");
  property p_bit2_locked;
    @(posedge mclk_in) disable iff (reset_in)
      (smm_space_lock && !low_smm_select[1]) |=> $stable(low_smm_select[0]);
  endproperty
  a_bit2_locked: assert property (p_bit2_locked)
    else $error("bit2 wr");
  // a closed high segment must not raise the violation flag
  property p_high_remap_smm_segment_off;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && low_smm_select != 2'h0 && !viol_flag && req_valid_in &&
       req_cpu_in && !req_smm_in && !in_top_smm_segment &&
       req_addr_in >= `SSDL_HIGH_REMAP_SMM_SEGMENT_BASE && req_addr_in <= `SSDL_HIGH_REMAP_SMM_SEGMENT_LAST)
      |=> !viol_flag;
  endproperty
  a_high_remap_smm_segment_off: assert property (p_high_remap_smm_segment_off) else $error("high_remap_smm_segment open");
  property p_nonsmm_hub;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && req_valid_in && !req_smm_in && (in_high_remap_smm_segment || in_top_smm_segment))
      |=> rsp_valid_out && rsp_dest_out == SSDL_DST_HUB;
  endproperty
  a_nonsmm_hub: assert property (p_nonsmm_hub) else $error("not hub");
  property p_ab_closed;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && req_valid_in && in_ab && low_smm_select == 2'h0)
      |=> rsp_dest_out != SSDL_DST_DRAM;
  endproperty
  a_ab_closed: assert property (p_ab_closed)
    else $error("ab to dram");
  property p_ab_noncpu;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && req_valid_in && in_ab && low_smm_select[1] &&
       !req_cpu_in) |=> rsp_dest_out != SSDL_DST_DRAM;
  endproperty
  a_ab_noncpu: assert property (p_ab_noncpu)
    else $error("non cpu ab");
  property p_clear;
    @(posedge mclk_in) disable iff (reset_in)
      (clk_en_in && cfg_wr_in && cfg_sel_in == 2'h0 &&
       cfg_wdata_in[0] && !hit_viol) |=> !viol_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule
`default_nettype wire

/* test/ssdl_host_model.sv */
// host bus partner model issuing single access pulses
`timescale 1ns/1ns
`default_nettype none
module ssdl_host_model (
  input wire logic mclk_in,
  output logic req_valid_out,
  output logic [31:0] req_addr_out,
  output logic [4:0] req_attr_out // cpu smm code write wb
);
  // ==========================================================
  // access issue
  initial begin
    req_valid_out = 1'b0;
    req_addr_out = 32'h0000_0000;
    req_attr_out = 5'h00;
  end
  // one access, held across exactly one taking edge
  task automatic issue(input logic [31:0] a, input logic [4:0] f);
    @(posedge mclk_in);
    req_valid_out <= 1'b1;
    req_addr_out <= a;
    req_attr_out <= f;
    @(posedge mclk_in);
    // released qualifiers flip so a stale value never passes as live
    req_valid_out <= 1'b0;
    req_addr_out <= ~a;
    req_attr_out <= ~f;
  endtask
endmodule
`default_nettype wire

/* test/ssdl_top_tb.sv */
// self-checking bench for the smm decode and lock block
`timescale 1ns/1ns
`default_nettype none
`include "ssdl_regs.svh"
module ssdl_top_tb;
  import ssdl_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic cfg_wr_in = 1'b0;
  logic [1:0] cfg_sel_in = 2'h0;
  logic [7:0] cfg_wdata_in = 8'h00;
  logic [31:0] tom_in = 32'h0800_0000; // fixed top of memory
  logic req_valid;
  logic [31:0] req_addr;
  logic [4:0] req_attr;
  logic [7:0] ctrl_out, rowpop0_out, rowpop1_out;
  logic rsp_valid_out;
  ssdl_dest_t rsp_dest_out;
  // reference state and counters
  logic [7:0] m_ctrl = 8'h00;
  logic [7:0] m_row [2];
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] r;
  always #4 mclk_in = ~mclk_in;
  ssdl_host_model u_host (.mclk_in(mclk_in), .req_valid_out(req_valid),
    .req_addr_out(req_addr), .req_attr_out(req_attr));
  ssdl_top DUT (.mclk_in(mclk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .cfg_wr_in(cfg_wr_in), .cfg_sel_in(cfg_sel_in),
    .cfg_wdata_in(cfg_wdata_in), .tom_in(tom_in), .req_valid_in(req_valid),
    .req_addr_in(req_addr), .req_cpu_in(req_attr[4]),
    .req_smm_in(req_attr[3]), .req_code_in(req_attr[2]),
    .req_write_in(req_attr[1]), .req_wb_in(req_attr[0]),
    .ctrl_out(ctrl_out), .rowpop0_out(rowpop0_out),
    .rowpop1_out(rowpop1_out), .rsp_valid_out(rsp_valid_out),
    .rsp_dest_out(rsp_dest_out));
  // ==========================================================
  // compare and closing tasks
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t register %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_route(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t route %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 840 cycles needed
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  // ==========================================================
  // bus tasks with the reference model folded in
  task automatic do_reset;
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    m_ctrl = 8'h00;
    m_row = '{8'h00, 8'h00};
    #1;
    chk_reg(ctrl_out, 8'h00);
  endtask
  task automatic cfg_write(input logic [1:0] s, input logic [7:0] d);
    @(posedge mclk_in);
    cfg_wr_in <= 1'b1;
    cfg_sel_in <= s;
    cfg_wdata_in <= d;
    @(posedge mclk_in);
    cfg_wr_in <= 1'b0;
    if (clk_en_in && s == 2'h0) begin
      // locked: only bit 2, and only while bit 3 reads one
      if (m_ctrl[1]) begin
        if (m_ctrl[3]) m_ctrl[2] = d[2];
      end else begin
        m_ctrl[7:1] = d[7:1];
      end
      if (d[0]) m_ctrl[0] = 1'b0;
    end else if (clk_en_in && s[1] && !m_ctrl[1]) begin
      m_row[s[0]] = d;
    end
    #1;
    chk_reg(ctrl_out, m_ctrl);
  endtask
  task automatic access(input logic [31:0] a, input logic [4:0] f);
    logic [31:0] sz;
    logic [2:0] e;
    logic [1:0] oth;
    sz = (m_ctrl[5:4] == 2'h3) ? `SSDL_TOP_SMM_SEGMENT_1M :
      (m_ctrl[5:4] == 2'h2) ? `SSDL_TOP_SMM_SEGMENT_512K : 32'h0000_0000;
    oth = (m_ctrl[7:6] != 2'h0) ? SSDL_DST_GFX : SSDL_DST_HUB;
    e = 3'h0; // unknown route: only the valid strobe is checked
    if (a >= `SSDL_AB_BASE && a <= `SSDL_AB_LAST) begin
      case (m_ctrl[3:2])
        2'h0: e = {1'b1, oth};
        2'h1: e = {1'b1, SSDL_DST_DRAM};
        2'h2: e = {1'b1, (&f[4:2] && !f[1]) ? SSDL_DST_DRAM : oth};
        default: e = {1'b1, (&f[4:3]) ? SSDL_DST_DRAM : oth};
      endcase
    end
    if ((a >= `SSDL_HIGH_REMAP_SMM_SEGMENT_BASE && a <= `SSDL_HIGH_REMAP_SMM_SEGMENT_LAST &&
        m_ctrl[5:4] != 2'h0 && m_ctrl[3:2] == 2'h0) ||
        (sz != 0 && a >= tom_in - sz && a < tom_in)) begin
      e = {1'b1, (&f[4:3]) ? SSDL_DST_DRAM : SSDL_DST_HUB};
      if (f[4] && !f[3] && !f[0]) m_ctrl[0] = 1'b1;
    end
    u_host.issue(a, f);
    // the response pulse stands only from the taking edge to the next
    #1;
    chk_route({rsp_valid_out, e[2] ? rsp_dest_out : 2'h0},
      {1'b1, e[1:0]});
    chk_reg(ctrl_out, m_ctrl);
  endtask
  task automatic traffic;
    repeat (6) begin
      r = $urandom;
      access(`SSDL_AB_BASE + (r & 32'h0001_FFFF), r[4:0]);
      access(`SSDL_HIGH_REMAP_SMM_SEGMENT_BASE + (r & 32'h0001_FFFF), r[9:5]);
      access(tom_in - 32'h0010_0000 + (r & 32'h000F_FFFF),
        r[14:10]);
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h788c8118));
    do_reset();
    // every low and upper select, graphics select varied alongside
    for (int lo = 0; lo < 4; lo++) begin
      for (int up = 0; up < 4; up++) begin
        r = $urandom;
        cfg_write(2'h0, {up[1:0], up[1:0], lo[1:0], 1'b0, r[0]});
        traffic();
      end
    end
    // two lock phases: bit 3 clear freezes bit 2, bit 3 set frees it
    for (int ph = 0; ph < 2; ph++) begin
      do_reset();
      cfg_write(2'h2, 8'h5A);
      cfg_write(2'h3, 8'hC3);
      cfg_write(2'h1, 8'hFF);
      @(posedge mclk_in);
      clk_en_in <= 1'b0;
      cfg_write(2'h0, 8'hFE); // frozen write
      @(posedge mclk_in);
      clk_en_in <= 1'b1;
      cfg_write(2'h0, ph ? 8'h08 : 8'h04);
      cfg_write(2'h0, ph ? 8'hBA : 8'hB6);
      repeat (10) begin
        r = $urandom;
        cfg_write(r[9:8], r[7:0]);
      end
      traffic();
      repeat (3) @(posedge mclk_in);
      #1;
      chk_reg(rowpop0_out, m_row[0]);
      chk_reg(rowpop1_out, m_row[1]);
    end
    do_reset();
    final_report();
  end
endmodule
`default_nettype wire
